//--- hw/alu_pkg.sv
// constants, types and register map shared by the accumulator datapath files
package alu_pkg;

	localparam int DATA_W = 8;
	localparam int NIB_W = 4;
	localparam int BUS_W = 32;
	localparam int ADR_W = 8;

	// register byte addresses, one aligned word each
	localparam logic [ADR_W-1:0] ADDR_ACC = 8'h00;
	localparam logic [ADR_W-1:0] ADDR_FILE = 8'h04;
	localparam logic [ADR_W-1:0] ADDR_LIT = 8'h08;
	localparam logic [ADR_W-1:0] ADDR_STATUS = 8'h0C;
	localparam logic [ADR_W-1:0] ADDR_CMD = 8'h10;

	// status field positions
	localparam int ST_CARRY = 0;
	localparam int ST_DIGIT = 1;
	localparam int ST_ZERO = 2;
	localparam int ST_W = 3;

	// command field layout
	localparam int CMD_OP_W = 3;
	localparam int CMD_DEST_BIT = 3;
	localparam int CMD_W = 4;

	// reset values
	localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
	localparam logic [DATA_W-1:0] FILE_RST = 8'h00;
	localparam logic [DATA_W-1:0] LIT_RST = 8'h00;
	localparam logic [ST_W-1:0] STATUS_RST = 3'h0;
	localparam logic [CMD_W-1:0] CMD_RST = 4'h0;
	localparam logic [BUS_W-1:0] BUS_ZERO = 32'h0000_0000;

	// destination select values
	localparam logic DEST_ACC = 1'b0;
	localparam logic DEST_FILE = 1'b1;

	typedef enum logic [CMD_OP_W-1:0] {
		OP_SUB_ACC_FROM_LITERAL,
		OP_SUB_ACC_FROM_FILE,
		OP_XOR_LITERAL_ACC,
		OP_SWAP_FILE_NIBBLES,
		OP_XOR_ACC_FILE
	} alu_op_t;

	typedef struct packed {
		logic [CMD_OP_W-1:0] op;
		logic dest;
		logic [DATA_W-1:0] acc;
		logic [DATA_W-1:0] file_val;
		logic [DATA_W-1:0] literal;
	} alu_in_t;

	typedef struct packed {
		logic valid;
		logic to_file;
		logic [DATA_W-1:0] result;
		logic carry;
		logic digit_carry_flag;
		logic zero;
		logic upd_carry;
		logic upd_digit;
		logic upd_zero;
	} alu_out_t;

endpackage

//--- hw/alu_core.sv
// combinational core computing result and flags for one accumulator operation
`timescale 1ns/1ps
`default_nettype none

module alu_core (
	input wire alu_pkg::alu_in_t in_i,
	output alu_pkg::alu_out_t out_o
);

	// a minus b with the no-borrow carry, nine bits wide
	function automatic logic [alu_pkg::DATA_W:0] sub9(input logic [alu_pkg::DATA_W-1:0] a,
		input logic [alu_pkg::DATA_W-1:0] b);
		logic [alu_pkg::DATA_W:0] d;
		d = {1'b0, a} - {1'b0, b};
		sub9 = {~d[alu_pkg::DATA_W], d[alu_pkg::DATA_W-1:0]};
	endfunction

	// no-borrow on the low nibbles
	function automatic logic nib_ge(input logic [alu_pkg::DATA_W-1:0] a, input logic [alu_pkg::DATA_W-1:0] b);
		nib_ge = (a[alu_pkg::NIB_W-1:0] >= b[alu_pkg::NIB_W-1:0]);
	endfunction

	// operation select and flag update masks
	always_comb begin
		logic [alu_pkg::DATA_W:0] diff;
		diff = '0;
		out_o = '0;
		case (in_i.op)
			alu_pkg::OP_SUB_ACC_FROM_LITERAL: begin
				diff = sub9(in_i.literal, in_i.acc);
				out_o.valid = 1'b1;
				out_o.result = diff[alu_pkg::DATA_W-1:0];
				out_o.carry = diff[alu_pkg::DATA_W];
				out_o.digit_carry_flag = nib_ge(in_i.literal, in_i.acc);
				out_o.upd_carry = 1'b1;
				out_o.upd_digit = 1'b1;
				out_o.upd_zero = 1'b1;
			end
			alu_pkg::OP_SUB_ACC_FROM_FILE: begin
				diff = sub9(in_i.file_val, in_i.acc);
				out_o.valid = 1'b1;
				out_o.to_file = (in_i.dest == alu_pkg::DEST_FILE);
				out_o.result = diff[alu_pkg::DATA_W-1:0];
				out_o.carry = diff[alu_pkg::DATA_W];
				out_o.digit_carry_flag = nib_ge(in_i.file_val, in_i.acc);
				out_o.upd_carry = 1'b1;
				out_o.upd_digit = 1'b1;
				out_o.upd_zero = 1'b1;
			end
			alu_pkg::OP_XOR_LITERAL_ACC: begin
				out_o.valid = 1'b1;
				out_o.result = in_i.acc ^ in_i.literal;
				out_o.upd_zero = 1'b1;
			end
			alu_pkg::OP_SWAP_FILE_NIBBLES: begin
				out_o.valid = 1'b1;
				out_o.to_file = (in_i.dest == alu_pkg::DEST_FILE);
				out_o.result = {in_i.file_val[alu_pkg::NIB_W-1:0],
					in_i.file_val[alu_pkg::DATA_W-1:alu_pkg::NIB_W]};
			end
			alu_pkg::OP_XOR_ACC_FILE: begin
				out_o.valid = 1'b1;
				out_o.to_file = (in_i.dest == alu_pkg::DEST_FILE);
				out_o.result = in_i.acc ^ in_i.file_val;
				out_o.upd_zero = 1'b1;
			end
			default: begin
				out_o.valid = 1'b0; // unused codes do nothing
			end
		endcase
		out_o.zero = (out_o.result == '0);
	end

endmodule

`default_nettype wire

//--- hw/sub_xor_swap_alu_ops.sv
// accumulator datapath for subtract, exclusive-or and nibble swap behind a wishbone slave
//
// Contract
// - literal minus accumulator to accumulator; carry and digit carry mean no borrow
// - file minus accumulator; destination bit 0 accumulator, 1 file register
// - file subtract: carry and digit carry clear when accumulator part exceeds file part
// - accumulator xor literal into accumulator, only zero flag updated
// - swap file nibbles into destination, no flag changes
// - accumulator xor file into destination, only zero flag updated
`timescale 1ns/1ps
`default_nettype none

module sub_xor_swap_alu_ops (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [alu_pkg::ADR_W-1:0] adr_i,
	input wire logic [alu_pkg::BUS_W-1:0] dat_i,
	input wire logic [3:0] sel_i,
	output logic [alu_pkg::BUS_W-1:0] dat_o,
	output logic ack_o
);

	logic ack_reg;
	logic [alu_pkg::BUS_W-1:0] rdata_reg;
	logic [alu_pkg::DATA_W-1:0] acc_reg;
	logic [alu_pkg::DATA_W-1:0] file_reg;
	logic [alu_pkg::DATA_W-1:0] lit_reg;
	logic [alu_pkg::ST_W-1:0] status_reg;
	logic [alu_pkg::CMD_W-1:0] cmd_reg;
	logic req;
	logic wr_take;
	logic exec;
	alu_pkg::alu_in_t alu_in;
	alu_pkg::alu_out_t alu_out;

	// bus request decode; a write lands at the edge where ack is high
	assign req = cyc_i & stb_i;
	assign wr_take = req & we_i & ack_reg & sel_i[0];
	assign exec = wr_take & (adr_i == alu_pkg::ADDR_CMD);

	// operands for the core come from the bus write data and held registers
	assign alu_in.op = dat_i[alu_pkg::CMD_OP_W-1:0];
	assign alu_in.dest = dat_i[alu_pkg::CMD_DEST_BIT];
	assign alu_in.acc = acc_reg;
	assign alu_in.file_val = file_reg;
	assign alu_in.literal = lit_reg;

	alu_core u_core (
		.in_i(alu_in),
		.out_o(alu_out)
	);

	// one wait state, ack drops the cycle after it was given
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req & ~ack_reg;
		end
	end

	// read data captured as ack rises; unmapped addresses read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_reg <= alu_pkg::BUS_ZERO;
		end else if (req & ~ack_reg) begin
			rdata_reg <= alu_pkg::BUS_ZERO;
			case (adr_i)
				alu_pkg::ADDR_ACC: rdata_reg[alu_pkg::DATA_W-1:0] <= acc_reg;
				alu_pkg::ADDR_FILE: rdata_reg[alu_pkg::DATA_W-1:0] <= file_reg;
				alu_pkg::ADDR_LIT: rdata_reg[alu_pkg::DATA_W-1:0] <= lit_reg;
				alu_pkg::ADDR_STATUS: rdata_reg[alu_pkg::ST_W-1:0] <= status_reg;
				alu_pkg::ADDR_CMD: rdata_reg[alu_pkg::CMD_W-1:0] <= cmd_reg;
				default: rdata_reg <= alu_pkg::BUS_ZERO;
			endcase
		end
	end

	assign ack_o = ack_reg;
	assign dat_o = rdata_reg;

	// accumulator: operation result when aimed here, else software write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc_reg <= alu_pkg::ACC_RST;
		end else if (exec & alu_out.valid & ~alu_out.to_file) begin
			acc_reg <= alu_out.result;
		end else if (wr_take & (adr_i == alu_pkg::ADDR_ACC)) begin
			acc_reg <= dat_i[alu_pkg::DATA_W-1:0];
		end
	end

	// file register image: written back when a file-sourced operation has destination bit one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			file_reg <= alu_pkg::FILE_RST;
		end else if (exec & alu_out.valid & alu_out.to_file) begin
			file_reg <= alu_out.result;
		end else if (wr_take & (adr_i == alu_pkg::ADDR_FILE)) begin
			file_reg <= dat_i[alu_pkg::DATA_W-1:0];
		end
	end

	// literal operand register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lit_reg <= alu_pkg::LIT_RST;
		end else if (wr_take & (adr_i == alu_pkg::ADDR_LIT)) begin
			lit_reg <= dat_i[alu_pkg::DATA_W-1:0];
		end
	end

	// last command written, readable back
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_reg <= alu_pkg::CMD_RST;
		end else if (exec) begin
			cmd_reg <= dat_i[alu_pkg::CMD_W-1:0];
		end
	end

	// status flags: each one only moves when its operation updates it or software writes the status word
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_reg <= alu_pkg::STATUS_RST;
		end else if (exec & alu_out.valid) begin
			if (alu_out.upd_carry) begin
				status_reg[alu_pkg::ST_CARRY] <= alu_out.carry;
			end
			if (alu_out.upd_digit) begin
				status_reg[alu_pkg::ST_DIGIT] <= alu_out.digit_carry_flag;
			end
			if (alu_out.upd_zero) begin
				status_reg[alu_pkg::ST_ZERO] <= alu_out.zero;
			end
		end else if (wr_take & (adr_i == alu_pkg::ADDR_STATUS)) begin
			status_reg <= dat_i[alu_pkg::ST_W-1:0];
		end
	end

	// checks on the executed operations
	sub_lit_result_a: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && dat_i[alu_pkg::CMD_OP_W-1:0] == alu_pkg::OP_SUB_ACC_FROM_LITERAL
		|=> acc_reg == 8'($past(lit_reg) - $past(acc_reg))
		&& status_reg[alu_pkg::ST_CARRY] == ($past(acc_reg) <= $past(lit_reg))
		&& status_reg[alu_pkg::ST_DIGIT]
			== ($past(acc_reg[alu_pkg::NIB_W-1:0]) <= $past(lit_reg[alu_pkg::NIB_W-1:0])))
		else $error("literal subtract result or flags wrong");

	sub_file_dest_a: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && dat_i[alu_pkg::CMD_OP_W-1:0] == alu_pkg::OP_SUB_ACC_FROM_FILE
		|=> ($past(dat_i[alu_pkg::CMD_DEST_BIT])
			? (file_reg == 8'($past(file_reg) - $past(acc_reg)) && $stable(acc_reg))
			: (acc_reg == 8'($past(file_reg) - $past(acc_reg)) && $stable(file_reg))))
		else $error("file subtract went to wrong destination");

	sub_file_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && dat_i[alu_pkg::CMD_OP_W-1:0] == alu_pkg::OP_SUB_ACC_FROM_FILE
		|=> status_reg[alu_pkg::ST_CARRY] == ($past(acc_reg) <= $past(file_reg))
		&& status_reg[alu_pkg::ST_DIGIT]
			== ($past(acc_reg[alu_pkg::NIB_W-1:0]) <= $past(file_reg[alu_pkg::NIB_W-1:0])))
		else $error("file subtract carry flags wrong");

	xor_lit_only_z_a: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && dat_i[alu_pkg::CMD_OP_W-1:0] == alu_pkg::OP_XOR_LITERAL_ACC
		|=> acc_reg == ($past(acc_reg) ^ $past(lit_reg)) && $stable(file_reg)
		&& status_reg[alu_pkg::ST_DIGIT:alu_pkg::ST_CARRY] == $past(status_reg[alu_pkg::ST_DIGIT:alu_pkg::ST_CARRY]))
		else $error("literal xor result or flag mask wrong");

	swap_no_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && dat_i[alu_pkg::CMD_OP_W-1:0] == alu_pkg::OP_SWAP_FILE_NIBBLES
		|=> $stable(status_reg)
		&& ($past(dat_i[alu_pkg::CMD_DEST_BIT]) ? file_reg : acc_reg)
			== {$past(file_reg[alu_pkg::NIB_W-1:0]), $past(file_reg[alu_pkg::DATA_W-1:alu_pkg::NIB_W])})
		else $error("nibble swap wrong or flags moved");

	xor_file_dest_a: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && dat_i[alu_pkg::CMD_OP_W-1:0] == alu_pkg::OP_XOR_ACC_FILE
		|=> ($past(dat_i[alu_pkg::CMD_DEST_BIT]) ? file_reg : acc_reg) == ($past(acc_reg) ^ $past(file_reg))
		&& status_reg[alu_pkg::ST_DIGIT:alu_pkg::ST_CARRY] == $past(status_reg[alu_pkg::ST_DIGIT:alu_pkg::ST_CARRY]))
		else $error("file xor result or flag mask wrong");

	zero_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && alu_out.valid && alu_out.upd_zero
		|=> status_reg[alu_pkg::ST_ZERO]
			== (($past(alu_out.to_file) ? file_reg : acc_reg) == '0))
		else $error("zero flag does not match result");

	ack_one_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");

	// codes past the last operation are stored but move no datapath state
	op_code_inert_a: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && dat_i[alu_pkg::CMD_OP_W-1:0] > alu_pkg::OP_XOR_ACC_FILE
		|=> $stable(acc_reg) && $stable(file_reg) && $stable(status_reg))
		else $error("unused operation code changed datapath state");

	// a write without byte lane zero is acked but lands nowhere
	masked_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		req && we_i && ack_reg && !sel_i[0]
		|=> $stable(acc_reg) && $stable(file_reg) && $stable(lit_reg)
		&& $stable(status_reg) && $stable(cmd_reg))
		else $error("write without lane zero changed a register");

	ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
		req && !ack_o
		|=> ack_o)
		else $error("request not answered in the next cycle");

	rdata_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!(req && !ack_o)
		|=> $stable(dat_o))
		else $error("read data moved outside a capture edge");

	cmd_readback_a: assert property (@(posedge clk_i) disable iff (rst_i)
		exec
		|=> cmd_reg == $past(dat_i[alu_pkg::CMD_W-1:0]))
		else $error("command readback does not hold last command");

endmodule

`default_nettype wire

//--- sim/bus_host.sv
// wishbone classic master model standing in for the core decoder and data memory
`timescale 1ns/1ps
`default_nettype none

module bus_host (
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [alu_pkg::BUS_W-1:0] dat_i,
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [alu_pkg::ADR_W-1:0] adr_o,
	output logic [alu_pkg::BUS_W-1:0] dat_o,
	output logic [3:0] sel_o
);
	// idle bus from time zero
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 8'h00;
		dat_o = 32'h0000_0000;
		sel_o = 4'h0;
	end

	// one classic cycle; request held until ack is sampled high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] q);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		dat_o <= d;
		sel_o <= s;
		do @(posedge clk_i); while (ack_i !== 1'b1);
		q = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		we_o <= 1'b0;
		dat_o <= ~d;
	endtask
endmodule
`default_nettype wire

//--- sim/test_sub_xor_swap_alu_ops.sv
// self-checking bench for the subtract, xor and swap datapath
`timescale 1ns/1ps
`default_nettype none

module test_sub_xor_swap_alu_ops;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc, stb, we, ack;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, q;
	logic [3:0] sel;
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;

	// 40 MHz clock
	always #12.5 clk_i = ~clk_i;

	sub_xor_swap_alu_ops i_sub_xor_swap_alu_ops (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .dat_i(wdat), .sel_i(sel), .dat_o(rdat), .ack_o(ack));
	bus_host u_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
		.adr_o(adr), .dat_o(wdat), .sel_o(sel));

	// verdict and end of run
	task automatic finish_test();
		if (miscompares == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// hang guard
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			finish_test();
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_host.xfer(1'b1, a, {24'h000000, d}, 4'hF, q);
	endtask

	task automatic rd_check(input string name, input logic [7:0] a, input logic [7:0] exp);
		u_host.xfer(1'b0, a, 32'h0000_0000, 4'hF, q);
		check(name, q, {24'h000000, exp});
	endtask

	// expected {acc, file, status} after one command
	function automatic logic [18:0] model(input logic [2:0] op, input logic d, input logic [7:0] a,
		input logic [7:0] f, input logic [7:0] l, input logic [2:0] s);
		logic [7:0] b, r;
		logic [2:0] st;
		b = (op == 3'h0 || op == 3'h2) ? l : f;
		st = s;
		if (op <= 3'h1) begin
			r = b - a;
			st[0] = (a <= b);
			st[1] = (a[3:0] <= b[3:0]);
		end else if (op == 3'h3) begin
			r = {f[3:0], f[7:4]};
		end else begin
			r = a ^ b;
		end
		if (op != 3'h3) st[2] = (r == 8'h00);
		if (op == 3'h0 || op == 3'h2 || !d) return {r, f, st};
		return {a, r, st};
	endfunction

	// load operands, execute, read back all three results
	task automatic run_case(input logic [2:0] op, input logic d, input logic [7:0] a, input logic [7:0] f,
		input logic [7:0] l, input logic [2:0] s);
		logic [18:0] e;
		e = model(op, d, a, f, l, s);
		wr(alu_pkg::ADDR_ACC, a);
		wr(alu_pkg::ADDR_FILE, f);
		wr(alu_pkg::ADDR_LIT, l);
		wr(alu_pkg::ADDR_STATUS, {5'h00, s});
		wr(alu_pkg::ADDR_CMD, {4'h0, d, op});
		rd_check("acc", alu_pkg::ADDR_ACC, e[18:11]);
		rd_check("file", alu_pkg::ADDR_FILE, e[10:3]);
		rd_check("status", alu_pkg::ADDR_STATUS, {5'h00, e[2:0]});
		rd_check("cmd", alu_pkg::ADDR_CMD, {4'h0, d, op});
	endtask

	// main sequence
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_check("acc reset", alu_pkg::ADDR_ACC, 8'h00);
		rd_check("status reset", alu_pkg::ADDR_STATUS, 8'h00);
		rd_check("file reset", alu_pkg::ADDR_FILE, 8'h00);
		rd_check("lit reset", alu_pkg::ADDR_LIT, 8'h00);
		rd_check("cmd reset", alu_pkg::ADDR_CMD, 8'h00);
		run_case(3'h0, 1'b0, 8'h10, 8'h00, 8'h0F, 3'h0);
		run_case(3'h0, 1'b1, 8'h3C, 8'h55, 8'h3C, 3'h0);
		run_case(3'h1, 1'b0, 8'h0F, 8'h20, 8'hAA, 3'h7);
		run_case(3'h1, 1'b1, 8'h21, 8'h21, 8'h00, 3'h0);
		run_case(3'h2, 1'b0, 8'hA5, 8'h00, 8'hA5, 3'h3);
		run_case(3'h2, 1'b1, 8'h3C, 8'h11, 8'hC3, 3'h7);
		run_case(3'h3, 1'b0, 8'h00, 8'h3C, 8'h00, 3'h5);
		run_case(3'h3, 1'b1, 8'hFF, 8'h1E, 8'h00, 3'h2);
		run_case(3'h4, 1'b1, 8'h5A, 8'h5A, 8'h00, 3'h3);
		run_case(3'h4, 1'b0, 8'hF0, 8'h0F, 8'h00, 3'h4);
		rd_check("unmapped", 8'h20, 8'h00);
		u_host.xfer(1'b1, alu_pkg::ADDR_ACC, 32'h0000_0077, 4'h0, q);
		rd_check("acc masked write", alu_pkg::ADDR_ACC, 8'hFF);
		wr(alu_pkg::ADDR_STATUS, 8'h05);
		wr(alu_pkg::ADDR_CMD, 8'h0D);
		rd_check("cmd inert", alu_pkg::ADDR_CMD, 8'h0D);
		rd_check("acc inert", alu_pkg::ADDR_ACC, 8'hFF);
		rd_check("file inert", alu_pkg::ADDR_FILE, 8'h0F);
		rd_check("status inert", alu_pkg::ADDR_STATUS, 8'h05);
		finish_test();
	end
endmodule
`default_nettype wire
